// ---- logic/pmt_timer.sv ----
// period match timer: AHB-Lite slave, prescaler, counter, comparator, interrupt
// assumes a single AHB-Lite master with word transfers, one clock sys_clk
//
// Functional notes
// - running counter increments per divided instruction clock
// - prescale 00 by 1, 01 by 4, 1x by 16
// - count equals period raises match output
// - match zeroes counter next cycle, clocks postscaler
// - count/period readable writable; reset 00h, FFh
// - count or control write clears both scalers
// - control write leaves count unchanged
// - postscale code plus one matches per event
// - bit 2 runs timer; control resets zero
// - control bit 7 reads zero, ignores writes
`timescale 1ns/1ps
`include "pmt_consts.svh"

module pmt_timer
    import pmt_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             matchOut,
    output logic             irq
);
    pmt_scaler_if sc ();

    pmt_bus_state_t busState;
    logic [7:0]  wrAddr;
    logic [7:0]  countReg;
    logic [7:0]  periodReg;
    pmt_ctrl_t   ctrl;
    logic [`PMT_ST_WIDTH-1:0] status;
    logic [`PMT_ST_WIDTH-1:0] mask;
    logic [1:0]  instrDiv;
    logic [3:0]  preCount;
    logic        countTick;
    logic        matchNow;
    logic        matchLate;
    logic        wrCount;
    logic        wrPeriod;
    logic        wrControl;
    logic        wrStatus;
    logic        wrMask;
    logic [`PMT_ST_WIDTH-1:0] next_status;
    logic [31:0] next_rdata;

    function automatic logic [3:0] preLimit(input logic [1:0] sel);
        unique case (sel)
            2'b00:   preLimit = 4'h0;
            2'b01:   preLimit = 4'h3;
            default: preLimit = 4'hf;
        endcase
    endfunction : preLimit

    // bus: address phase captured, write applied in data phase, zero wait
    wire addrPhase = hsel && hready && htrans[1];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busState <= PMT_BUS_IDLE;
            wrAddr   <= 8'h00;
        end else if (addrPhase && hwrite) begin
            busState <= PMT_BUS_WRITE;
            wrAddr   <= haddr;
        end else if (hready) begin
            busState <= PMT_BUS_IDLE;
        end
    end

    wire inWrite = (busState == PMT_BUS_WRITE);
    assign wrCount   = inWrite && (wrAddr == `PMT_OFF_COUNT);
    assign wrPeriod  = inWrite && (wrAddr == `PMT_OFF_PERIOD);
    assign wrControl = inWrite && (wrAddr == `PMT_OFF_CONTROL);
    assign wrStatus  = inWrite && (wrAddr == `PMT_OFF_STATUS);
    assign wrMask    = inWrite && (wrAddr == `PMT_OFF_MASK);

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr)
            `PMT_OFF_COUNT:   next_rdata = {24'h000000, countReg};
            `PMT_OFF_PERIOD:  next_rdata = {24'h000000, periodReg};
            `PMT_OFF_CONTROL: next_rdata = {25'h0000000, ctrl};
            `PMT_OFF_STATUS:  next_rdata = {30'h00000000, status};
            `PMT_OFF_MASK:    next_rdata = {30'h00000000, mask};
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // control: bit 7 dropped on write
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= `PMT_CONTROL_RST;
        end else if (wrControl) begin
            ctrl <= hwdata[6:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            periodReg <= `PMT_PERIOD_RST;
        end else if (wrPeriod) begin
            periodReg <= hwdata[7:0];
        end
    end

    // instruction clock: one tick every fourth sys_clk
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            instrDiv <= 2'h0;
        end else if (!ctrl.runEnable) begin
            instrDiv <= 2'h0;
        end else begin
            instrDiv <= (instrDiv == `PMT_INSTR_DIV) ? 2'h0 : instrDiv + 2'h1;
        end
    end

    wire instrTick = ctrl.runEnable && (instrDiv == `PMT_INSTR_DIV);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            preCount <= 4'h0;
        end else if (wrCount || wrControl) begin
            preCount <= 4'h0;
        end else if (instrTick) begin
            preCount <= (preCount >= preLimit(ctrl.preSel)) ? 4'h0 : preCount + 4'h1;
        end
    end

    assign countTick = instrTick && !wrCount && !wrControl && (preCount >= preLimit(ctrl.preSel));

    assign matchNow = (countReg == periodReg);

    // match pulse once per count tick, when count clock samples equality
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            matchLate <= 1'b0;
        end else begin
            matchLate <= countTick && matchNow;
        end
    end

    // count register: a write wins; control writes leave it alone
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            countReg <= `PMT_COUNT_RST;
        end else if (wrCount) begin
            countReg <= hwdata[7:0];
        end else if (countTick) begin
            countReg <= matchNow ? `PMT_COUNT_RST : countReg + 8'h01;
        end
    end

    assign sc.matchPulse      = matchLate;
    assign sc.scalerClear     = wrCount || wrControl;
    assign sc.postscaleSelect = ctrl.postSel;

    pmt_postscaler u_post (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .sc      (sc)
    );

    // sticky flags: set beats write-one-to-clear
    always_comb begin
        next_status = status;
        if (wrStatus) begin
            next_status = status & ~hwdata[`PMT_ST_WIDTH-1:0];
        end
        if (matchLate) begin
            next_status[`PMT_ST_MATCH] = 1'b1;
        end
        if (sc.postEvent) begin
            next_status[`PMT_ST_POST] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status <= 2'h0;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask <= 2'h0;
        end else if (wrMask) begin
            mask <= hwdata[`PMT_ST_WIDTH-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq      <= 1'b0;
            matchOut <= 1'b0;
        end else begin
            irq      <= |(next_status & mask);
            matchOut <= matchLate;
        end
    end

    sequence sq_match_tick;
        countTick && matchNow;
    endsequence

    // prescaler restarts from zero once it has released a count tick
    sequence sq_pre_wrap;
        preCount == 4'h0;
    endsequence

    sequence sq_read_addr;
        addrPhase && !hwrite;
    endsequence

    AST_RUN_OFF: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !ctrl.runEnable |-> !countTick)
        else $error("count tick while timer off");
    AST_COUNT_INC: assert property (@(posedge sys_clk) disable iff (!arst_n)
        countTick && !matchNow |=> countReg == $past(countReg) + 8'h01)
        else $error("counter did not increment");
    AST_MATCH_ZERO: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sq_match_tick |=> countReg == 8'h00 ##0 matchLate ##1 matchOut)
        else $error("match did not zero counter and pulse");
    AST_MATCH_OUT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        matchLate |-> $past(countTick) && $past(countReg) == $past(periodReg))
        else $error("match pulse without equality");
    AST_PRE_CLEAR: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (wrCount || wrControl) |=> preCount == 4'h0)
        else $error("prescaler not cleared by write");
    AST_CTRL_KEEP: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wrControl |=> countReg == $past(countReg))
        else $error("control write changed count");
    AST_PRE_DIV4: assert property (@(posedge sys_clk) disable iff (!arst_n)
        countTick && ctrl.preSel == 2'b01 |-> preCount == 4'h3 ##1 sq_pre_wrap)
        else $error("prescaler by 4 misbehaved");
    AST_BIT7_ZERO: assert property (@(posedge sys_clk) disable iff (!arst_n)
        addrPhase && !hwrite && haddr == `PMT_OFF_CONTROL |=> hrdata[31:7] == 25'h0000000)
        else $error("control bit 7 read back set");
    AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sc.postEvent |=> status[`PMT_ST_POST])
        else $error("interrupt flag not set");
    AST_PERIOD_RW: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wrPeriod |=> periodReg == $past(hwdata[7:0]))
        else $error("period write lost");

    // register access
    AST_COUNT_WRITE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wrCount |=> countReg == $past(hwdata[7:0]))
        else $error("count write lost");
    AST_CTRL_WRITE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wrControl |=> ctrl == $past(hwdata[6:0]))
        else $error("control write lost");
    AST_MASK_RW: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wrMask |=> mask == $past(hwdata[`PMT_ST_WIDTH-1:0]))
        else $error("mask write lost");
    AST_READ_COUNT: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sq_read_addr ##0 haddr == `PMT_OFF_COUNT |=> hrdata == {24'h000000, $past(countReg)})
        else $error("count read wrong");
    AST_READ_PERIOD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sq_read_addr ##0 haddr == `PMT_OFF_PERIOD |=> hrdata == {24'h000000, $past(periodReg)})
        else $error("period read wrong");
    AST_READ_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !(addrPhase && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    AST_RESP_OKAY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hreadyout && !hresp)
        else $error("bus response not ready and okay");

    // count clock
    AST_TICK_SPACING: assert property (@(posedge sys_clk) disable iff (!arst_n)
        instrTick |=> !instrTick [*3])
        else $error("instruction ticks closer than four clocks");
    AST_COUNT_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !countTick && !wrCount |=> $stable(countReg))
        else $error("count moved without a tick");
    AST_RUN_DIV_IDLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !ctrl.runEnable |=> instrDiv == 2'h0)
        else $error("instruction divider ran while off");
    AST_PRE_DIV1: assert property (@(posedge sys_clk) disable iff (!arst_n)
        instrTick && ctrl.preSel == 2'b00 && !wrCount && !wrControl |-> countTick)
        else $error("prescaler by 1 dropped a tick");
    AST_PRE_DIV16: assert property (@(posedge sys_clk) disable iff (!arst_n)
        countTick && ctrl.preSel[1] |-> preCount == 4'hf ##1 sq_pre_wrap)
        else $error("prescaler by 16 misbehaved");

    // match output and flags
    AST_MATCH_ONE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        matchOut |=> !matchOut)
        else $error("match output wider than one cycle");
    AST_MATCH_FLAG: assert property (@(posedge sys_clk) disable iff (!arst_n)
        matchLate |=> status[`PMT_ST_MATCH])
        else $error("match flag not set");
    AST_STATUS_STICKY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        status[`PMT_ST_POST] && !wrStatus |=> status[`PMT_ST_POST])
        else $error("interrupt flag dropped by itself");
    AST_STATUS_CLEAR: assert property (@(posedge sys_clk) disable iff (!arst_n)
        wrStatus && hwdata[`PMT_ST_POST] && !sc.postEvent |=> !status[`PMT_ST_POST])
        else $error("interrupt flag not cleared");
    // irq lags a mask write by one clock, so only unchanged masks are checked
    AST_IRQ_LEVEL: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !wrMask |=> irq == |(status & mask))
        else $error("interrupt level wrong");
endmodule : pmt_timer

// ---- logic/pmt_consts.svh ----
// period match timer: register offsets, field positions, reset values
// assumes inclusion by bare name from the package and modules
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

`define PMT_OFF_COUNT      8'h00
`define PMT_OFF_PERIOD     8'h04
`define PMT_OFF_CONTROL    8'h08
`define PMT_OFF_STATUS     8'h0c
`define PMT_OFF_MASK       8'h10

`define PMT_COUNT_RST      8'h00
`define PMT_PERIOD_RST     8'hff
`define PMT_CONTROL_RST    7'h00
`define PMT_CONTROL_MASK   8'h7f

`define PMT_RUN_BIT        2
`define PMT_PRE_LSB        0
`define PMT_POST_LSB       3

`define PMT_ST_MATCH       0
`define PMT_ST_POST        1
`define PMT_ST_WIDTH       2

// count input runs at oscillator / 4
`define PMT_INSTR_DIV      2'h3

`endif

// ---- logic/pmt_pkg.sv ----
// period match timer: shared types
// assumes the constants header sits beside this file
`include "pmt_consts.svh"

package pmt_pkg;
    typedef enum logic [1:0] {
        PMT_BUS_IDLE,
        PMT_BUS_WRITE
    } pmt_bus_state_t;

    typedef struct packed {
        logic [3:0] postSel;
        logic       runEnable;
        logic [1:0] preSel;
    } pmt_ctrl_t;
endpackage : pmt_pkg

// ---- logic/pmt_scaler_if.sv ----
// period match timer: carrier between core and postscaler
// assumes one clock domain
`timescale 1ns/1ps

interface pmt_scaler_if;
    logic       matchPulse;
    logic       scalerClear;
    logic [3:0] postscaleSelect;
    logic       postEvent;

    modport core   (output matchPulse, output scalerClear, output postscaleSelect, input postEvent);
    modport scaler (input matchPulse, input scalerClear, input postscaleSelect, output postEvent);
endinterface : pmt_scaler_if

// ---- logic/pmt_postscaler.sv ----
// period match timer: output postscaler
// assumes match pulses are single cycle
`timescale 1ns/1ps

module pmt_postscaler
    import pmt_pkg::*;
(
    input wire logic    sys_clk,
    input wire logic    arst_n,
    pmt_scaler_if.scaler sc
);
    logic [3:0] postCount;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            postCount <= 4'h0;
        end else if (sc.scalerClear) begin
            postCount <= 4'h0;
        end else if (sc.matchPulse) begin
            if (postCount == sc.postscaleSelect) begin
                postCount <= 4'h0;
            end else begin
                postCount <= postCount + 4'h1;
            end
        end
    end

    // event fires on the code+1 th match
    assign sc.postEvent = sc.matchPulse && !sc.scalerClear && (postCount == sc.postscaleSelect);

    AST_POST_DIV: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sc.matchPulse && !sc.scalerClear && postCount != sc.postscaleSelect
        |=> postCount == $past(postCount) + 4'h1)
        else $error("postscaler did not step");
    AST_POST_WRAP: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sc.postEvent |=> postCount == 4'h0)
        else $error("postscaler did not restart");
endmodule : pmt_postscaler

// ---- tb/period_match_timer_test.sv ----
// self-checking bench for the period match timer: bus access, match timing, postscaler, interrupt
// assumes the timer slave answers with zero wait states and hready follows hreadyout
`timescale 1ns/1ps
`include "pmt_consts.svh"
`define CHK(nm, ex, gt) begin testsRun++; if ((gt) !== (ex)) begin nErrors++; \
    $display("ERROR %s expected %h seen %h", nm, ex, gt); end end

module period_match_timer_test;
    logic             sys_clk = 1'b0;
    logic             arst_n  = 1'b0;
    logic             hsel    = 1'b0;
    logic [7:0]       haddr   = 8'h00;
    logic [1:0]       htrans  = 2'h0;
    logic             hwrite  = 1'b0;
    logic [31:0]      hwdata  = 32'h0;
    wire logic [31:0] hrdata;
    wire logic        hreadyout;
    wire logic        hresp;
    wire logic        matchOut;
    wire logic        irq;
    int               nErrors = 0;
    int               testsRun = 0;
    int               cyc = 0;
    int               lastHit = 0;
    int               gap = 0;
    int               nMatch = 0;
    integer           seed = 32'h176c;

    pmt_timer dut (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (3'h2),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .matchOut  (matchOut),
        .irq       (irq)
    );

    always #10 sys_clk = ~sys_clk;

    // spacing between match pulses, in sys_clk cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (matchOut === 1'b1) begin
            gap     <= cyc - lastHit;
            lastHit <= cyc;
            nMatch  <= nMatch + 1;
        end
        if (cyc > 20000) begin
            nErrors++;
            conclude();
        end
    end

    task automatic conclude();
        if (nErrors == 0 && testsRun > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic doReset();
        arst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
    endtask : doReset

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        q = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [31:0] ex);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        `CHK($sformatf("register %h", a), ex, q)
    endtask : rdChk

    task automatic settle(input logic ex);
        repeat (3) @(negedge sys_clk);
        `CHK("irq", ex, irq)
    endtask : settle

    function automatic int matchGap(input logic [7:0] p, input logic [1:0] pre);
        return (int'(p) + 1) * 4 * (pre == 2'h0 ? 1 : (pre == 2'h1 ? 4 : 16));
    endfunction : matchGap

    initial begin
        logic [7:0] p;
        logic [3:0] post;
        int         base;
        doReset();
        rdChk(`PMT_OFF_COUNT, 32'h0);
        rdChk(`PMT_OFF_PERIOD, 32'hff);
        rdChk(`PMT_OFF_CONTROL, 32'h0);
        rdChk(`PMT_OFF_STATUS, 32'h0);
        wr(`PMT_OFF_CONTROL, 32'hfb);
        rdChk(`PMT_OFF_CONTROL, 32'h7b);
        repeat (8) begin
            p = $random(seed);
            wr(`PMT_OFF_COUNT, {24'h0, p});
            rdChk(`PMT_OFF_COUNT, {24'h0, p});
            wr(`PMT_OFF_PERIOD, {24'h0, ~p});
            rdChk(`PMT_OFF_PERIOD, {24'h0, ~p});
            wr(`PMT_OFF_CONTROL, {25'h0, p[6:3], 1'b0, p[1:0]});
            rdChk(`PMT_OFF_COUNT, {24'h0, p});
        end
        // timer off: no match may appear even with count at the period
        wr(`PMT_OFF_PERIOD, {24'h0, p});
        base = nMatch;
        repeat (200) @(posedge sys_clk);
        `CHK("idle matches", base, nMatch)
        for (int i = 0; i < 4; i++) begin
            p = 8'h1 + ($random(seed) & 3);
            wr(`PMT_OFF_CONTROL, 32'h0);
            wr(`PMT_OFF_COUNT, 32'h0);
            wr(`PMT_OFF_PERIOD, {24'h0, p});
            wr(`PMT_OFF_CONTROL, {29'h0, 1'b1, i[1:0]});
            base = nMatch;
            repeat (4000) if (nMatch < base + 3) @(posedge sys_clk);
            `CHK("match spacing", matchGap(p, i[1:0]), gap)
        end
        post = $random(seed);
        wr(`PMT_OFF_CONTROL, 32'h0);
        wr(`PMT_OFF_STATUS, 32'h3);
        wr(`PMT_OFF_MASK, 32'h2);
        wr(`PMT_OFF_COUNT, 32'h0);
        wr(`PMT_OFF_PERIOD, 32'h1);
        base = nMatch;
        wr(`PMT_OFF_CONTROL, {25'h0, post, 1'b1, 2'h0});
        repeat (2000) if (irq !== 1'b1) @(negedge sys_clk);
        // irq rises with matchOut; the match counter sees that pulse one edge later
        repeat (2) @(posedge sys_clk);
        `CHK("matches per event", int'(post) + 1, nMatch - base)
        wr(`PMT_OFF_CONTROL, {25'h0, post, 1'b0, 2'h0});
        rdChk(`PMT_OFF_STATUS, 32'h3);
        wr(`PMT_OFF_MASK, 32'h0);
        settle(1'b0);
        wr(`PMT_OFF_MASK, 32'h2);
        settle(1'b1);
        wr(`PMT_OFF_STATUS, 32'h2);
        settle(1'b0);
        rdChk(`PMT_OFF_STATUS, 32'h1);
        // unmapped place reads zero and swallows writes
        wr(`PMT_OFF_COUNT, 32'h5a);
        wr(8'h20, 32'hffff_ffff);
        rdChk(8'h20, 32'h0);
        rdChk(`PMT_OFF_COUNT, 32'h5a);
        // reset in mid-run
        wr(`PMT_OFF_PERIOD, 32'h5);
        wr(`PMT_OFF_CONTROL, 32'h4);
        repeat (30) @(posedge sys_clk);
        doReset();
        rdChk(`PMT_OFF_COUNT, 32'h0);
        rdChk(`PMT_OFF_PERIOD, 32'hff);
        rdChk(`PMT_OFF_CONTROL, 32'h0);
        conclude();
    end
endmodule : period_match_timer_test
